// [src/adcsq_divider.sv]
// Conversion clock divider producing one tick per conversion clock period.
`timescale 1ns/10ps

module adcsq_divider (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control.
   input wire logic run,
   input wire logic rc_source,
   input wire logic [7:0] divide,
   input wire logic rc_tick,
   // Result.
   output logic tick
);

   typedef struct packed {
      logic [7:0] count;
      logic tick;
   } adcsq_div_type;

   adcsq_div_type state;
   adcsq_div_type next_state;

   // Count peripheral clocks; period is divide+1, unless the RC source is chosen.
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (!run) begin
         next_state.count = 8'h00;
      end else if (rc_source) begin
         next_state.tick = rc_tick;
      end else if (state.count >= divide) begin
         next_state.count = 8'h00;
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count + 8'h01;
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign tick = state.tick;

endmodule

// [src/adcsq_pkg.sv]
// Package with register map, field positions and reset values of the converter sequencing control.
package adcsq_pkg;

   // ---------------------------------------------------------------
   // Register byte offsets on the AXI4-Lite bus.
   // ---------------------------------------------------------------
   localparam logic [5:0] ADDR_CONTROL_ONE = 6'h00;
   localparam logic [5:0] ADDR_CONTROL_TWO = 6'h04;
   localparam logic [5:0] ADDR_CONTROL_THREE = 6'h08;
   localparam logic [5:0] ADDR_DMA_CONFIG = 6'h0C;
   localparam logic [5:0] ADDR_CH123_SELECT = 6'h10;
   localparam logic [5:0] ADDR_STATUS = 6'h14;
   localparam logic [5:0] ADDR_SCAN_SELECT = 6'h18;

   // ---------------------------------------------------------------
   // Writable bit masks and reset values.
   // ---------------------------------------------------------------
   localparam logic [15:0] MASK_CONTROL_ONE = 16'h04F1;
   localparam logic [15:0] MASK_CONTROL_TWO = 16'hE77F;
   localparam logic [15:0] MASK_CONTROL_THREE = 16'h9FFF;
   localparam logic [15:0] MASK_DMA_CONFIG = 16'h0107;
   localparam logic [15:0] MASK_CH123 = 16'h0707;
   localparam logic [15:0] RESET_REG = 16'h0000;

   // ---------------------------------------------------------------
   // Field positions.
   // ---------------------------------------------------------------
   localparam int BIT_ENABLE = 0;
   localparam int BIT_TRIG_GROUP = 4;
   localparam int LSB_TRIG_SRC = 5;
   localparam int BIT_TWELVE = 10;
   localparam int BIT_SCAN_EN = 10;
   localparam int LSB_CHAN_CNT = 8;
   localparam int BIT_BUF_STATUS = 7;
   localparam int LSB_INC_RATE = 2;
   localparam int BIT_SPLIT = 1;
   localparam int BIT_ALT = 0;
   localparam int BIT_CLK_SRC = 15;
   localparam int LSB_SAMP_TIME = 8;
   localparam int BIT_DMA_EN = 8;
   localparam int LSB_NEG_B = 9;
   localparam logic [2:0] TRIG_AUTO = 3'h7;
   localparam logic [4:0] SCAN_LAST = 5'h1F;

   typedef enum logic [1:0] {adcsq_idle, adcsq_sample, adcsq_convert} adcsq_phase_type;

endpackage

// [src/adcsq_rate.sv]
// Rate counter that pulses after every N+1 completed conversions.
`timescale 1ns/10ps

module adcsq_rate (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Control.
   input wire logic run,
   input wire logic [4:0] limit,
   input wire logic done,
   // Result.
   output logic hit
);

   typedef struct packed {
      logic [4:0] count;
      logic hit;
   } adcsq_rate_type;

   adcsq_rate_type state;
   adcsq_rate_type next_state;

   // Restart on threshold and while disabled.
   always_comb begin
      next_state = state;
      next_state.hit = 1'b0;
      if (!run) begin
         next_state.count = 5'h00;
      end else if (done) begin
         if (state.count >= limit) begin
            next_state.count = 5'h00;
            next_state.hit = 1'b1;
         end else begin
            next_state.count = state.count + 5'h01;
         end
      end
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign hit = state.hit;

endmodule

// [src/adcsq_top.sv]
// Sequencing and configuration control of the converter with an AXI4-Lite register slave.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/10ps

module adcsq_top #(
   parameter int CONV_CLOCKS = 14
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [5:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [5:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Converter events.
   input wire logic rc_tick,
   input wire logic ext_trigger,
   // Sequencer outputs.
   output logic sample_active,
   output logic conv_start,
   output logic conv_done,
   output logic [1:0] conv_channel,
   output logic [4:0] scan_input,
   output logic [3:0] result_slot,
   output logic conv_irq,
   output logic dma_increment,
   output logic [7:0] dma_words
);

   typedef struct packed {
      logic awready;
      logic wready;
      logic have_aw;
      logic have_w;
      logic [5:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] ctl_one;
      logic [15:0] ctl_two;
      logic [15:0] ctl_three;
      logic [15:0] dma_cfg;
      logic [15:0] ch123;
      logic [15:0] scan_sel;
      adcsq_pkg::adcsq_phase_type phase;
      logic sampling;
      logic [4:0] samp_count;
      logic [4:0] conv_count;
      logic [1:0] channel;
      logic [4:0] scan_input;
      logic [3:0] slot;
      logic half;
      logic start;
      logic done;
      logic irq;
      logic dma_inc;
      logic [7:0] dma_words;
   } adcsq_top_type;

   adcsq_top_type state;
   adcsq_top_type next_state;
   logic [1:0] trig_sync;
   logic trig_seen;
   logic tad_tick;
   logic rate_hit;

   // Merge a write into a register through byte strobes and the writable mask.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                         input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] bytes;
      bytes = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
      merge = bytes & mask;
   endfunction

   // Number of channels converted minus one for the channel count code.
   function automatic logic [1:0] last_channel(input logic [1:0] code, input logic twelve);
      if (twelve) begin
         last_channel = 2'd0;
      end else if (code[1]) begin
         last_channel = 2'd3;
      end else begin
         last_channel = {1'b0, code[0]};
      end
   endfunction

   // Next scanned input after the current one, wrapping among the set scan bits.
   function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [15:0] sel);
      logic [4:0] idx;
      logic found;
      next_scan = cur;
      found = 1'b0;
      for (int k = 1; k <= 16; k++) begin
         idx = 5'((int'(cur) + k) % 16);
         if (!found && sel[idx[3:0]]) begin
            next_scan = idx;
            found = 1'b1;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Clock divider and rate counter.
   // ---------------------------------------------------------------
   wire logic conv_on = state.ctl_one[adcsq_pkg::BIT_ENABLE];
   wire logic dma_on = state.dma_cfg[adcsq_pkg::BIT_DMA_EN];
   wire logic twelve = state.ctl_one[adcsq_pkg::BIT_TWELVE];
   wire logic [2:0] trig_src = state.ctl_one[adcsq_pkg::LSB_TRIG_SRC +: 3];
   wire logic auto_conv = (trig_src == adcsq_pkg::TRIG_AUTO) && !state.ctl_one[adcsq_pkg::BIT_TRIG_GROUP];
   wire logic [4:0] rate_field = state.ctl_two[adcsq_pkg::LSB_INC_RATE +: 5];
   wire logic [4:0] rate_limit = dma_on ? rate_field : {1'b0, rate_field[3:0]};

   adcsq_divider u_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(conv_on),
      .rc_source(state.ctl_three[adcsq_pkg::BIT_CLK_SRC]),
      .divide(state.ctl_three[7:0]),
      .rc_tick(rc_tick),
      .tick(tad_tick)
   );

   adcsq_rate u_rate (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(conv_on),
      .limit(rate_limit),
      .done(next_state.done),
      .hit(rate_hit)
   );

   // Trigger pin is asynchronous and passes three flip-flops first.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_sync <= 2'b00;
         trig_seen <= 1'b0;
      end else begin
         trig_sync <= {trig_sync[0], ext_trigger};
         trig_seen <= trig_sync[1];
      end
   end

   // ---------------------------------------------------------------
   // Bus slave and sequencer.
   // ---------------------------------------------------------------
   always_comb begin
      logic [15:0] rd;
      logic write_go;
      rd = 16'h0000;
      next_state = state;
      next_state.start = 1'b0;
      next_state.done = 1'b0;
      next_state.irq = 1'b0;
      next_state.dma_inc = 1'b0;
      // Address and data are accepted in either order and held until both arrive.
      next_state.awready = !state.have_aw && !state.bvalid;
      next_state.wready = !state.have_w && !state.bvalid;
      if (s_axi_awvalid && state.awready) begin
         next_state.have_aw = 1'b1;
         next_state.awaddr = s_axi_awaddr;
         next_state.awready = 1'b0;
      end
      if (s_axi_wvalid && state.wready) begin
         next_state.have_w = 1'b1;
         next_state.wdata = s_axi_wdata;
         next_state.wstrb = s_axi_wstrb;
         next_state.wready = 1'b0;
      end
      write_go = state.have_aw && state.have_w && !state.bvalid;
      if (write_go) begin
         next_state.have_aw = 1'b0;
         next_state.have_w = 1'b0;
         next_state.bvalid = 1'b1;
         next_state.bresp = 2'b00;
         unique case (state.awaddr)
            adcsq_pkg::ADDR_CONTROL_ONE:
               next_state.ctl_one = merge(state.ctl_one, state.wdata, state.wstrb, adcsq_pkg::MASK_CONTROL_ONE);
            adcsq_pkg::ADDR_CONTROL_TWO: begin
               // Half status is hardware owned; keep it across writes.
               next_state.ctl_two = merge(state.ctl_two, state.wdata, state.wstrb, adcsq_pkg::MASK_CONTROL_TWO);
            end
            adcsq_pkg::ADDR_CONTROL_THREE:
               next_state.ctl_three = merge(state.ctl_three, state.wdata, state.wstrb,
                                            adcsq_pkg::MASK_CONTROL_THREE);
            adcsq_pkg::ADDR_DMA_CONFIG:
               next_state.dma_cfg = merge(state.dma_cfg, state.wdata, state.wstrb,
                                          adcsq_pkg::MASK_DMA_CONFIG);
            adcsq_pkg::ADDR_CH123_SELECT:
               next_state.ch123 = merge(state.ch123, state.wdata, state.wstrb, adcsq_pkg::MASK_CH123);
            adcsq_pkg::ADDR_SCAN_SELECT:
               next_state.scan_sel = merge(state.scan_sel, state.wdata, state.wstrb, 16'hFFFF);
            adcsq_pkg::ADDR_STATUS: ;
            default:
               next_state.bresp = 2'b10;
         endcase
      end
      if (state.bvalid && s_axi_bready) begin
         next_state.bvalid = 1'b0;
      end
      // Reads answer one cycle after the address is taken; twelve-bit mode masks fields.
      next_state.arready = !state.rvalid && !s_axi_arvalid;
      if (s_axi_arvalid && !state.rvalid && !state.arready) begin
         next_state.arready = 1'b1;
      end
      if (s_axi_arvalid && state.arready) begin
         next_state.arready = 1'b0;
         next_state.rvalid = 1'b1;
         next_state.rresp = 2'b00;
         unique case (s_axi_araddr)
            adcsq_pkg::ADDR_CONTROL_ONE: rd = state.ctl_one;
            adcsq_pkg::ADDR_CONTROL_TWO: begin
               rd = state.ctl_two;
               rd[adcsq_pkg::BIT_BUF_STATUS] = state.half;
               if (twelve) begin
                  rd[adcsq_pkg::LSB_CHAN_CNT +: 2] = 2'b00;
               end
            end
            adcsq_pkg::ADDR_CONTROL_THREE: rd = state.ctl_three;
            adcsq_pkg::ADDR_DMA_CONFIG: rd = state.dma_cfg;
            adcsq_pkg::ADDR_CH123_SELECT: rd = twelve ? 16'h0000 : state.ch123;
            adcsq_pkg::ADDR_STATUS: rd = {9'h000, state.scan_input, state.channel};
            adcsq_pkg::ADDR_SCAN_SELECT: rd = state.scan_sel;
            default: next_state.rresp = 2'b10;
         endcase
         next_state.rdata = {16'h0000, rd};
      end
      if (state.rvalid && s_axi_rready) begin
         next_state.rvalid = 1'b0;
      end
      // Sample and convert sequence.
      unique case (state.phase)
         adcsq_pkg::adcsq_idle: begin
            next_state.samp_count = 5'h00;
            if (conv_on) begin
               next_state.phase = adcsq_pkg::adcsq_sample;
            end
         end
         adcsq_pkg::adcsq_sample: begin
            if (auto_conv) begin
               // Internal counter ends sampling after the auto-sample time.
               if (tad_tick) begin
                  next_state.samp_count = state.samp_count + 5'h01;
               end
               if (state.samp_count >= state.ctl_three[adcsq_pkg::LSB_SAMP_TIME +: 5]) begin
                  next_state.phase = adcsq_pkg::adcsq_convert;
                  next_state.start = 1'b1;
               end
            end else if (trig_seen) begin
               next_state.phase = adcsq_pkg::adcsq_convert;
               next_state.start = 1'b1;
            end
         end
         adcsq_pkg::adcsq_convert: begin
            next_state.samp_count = 5'h00;
            if (tad_tick) begin
               next_state.conv_count = state.conv_count + 5'h01;
            end
            if (state.conv_count >= 5'(CONV_CLOCKS - 1) && tad_tick) begin
               next_state.conv_count = 5'h00;
               next_state.done = 1'b1;
               // Slot of this result; DMA keeps a single slot that the reader must drain.
               next_state.slot = dma_on ? 4'h0 : state.slot + 4'h1;
               if (state.channel >= last_channel(state.ctl_two[adcsq_pkg::LSB_CHAN_CNT +: 2], twelve)) begin
                  next_state.channel = 2'd0;
                  next_state.phase = adcsq_pkg::adcsq_sample;
                  if (state.ctl_two[adcsq_pkg::BIT_SCAN_EN]) begin
                     next_state.scan_input = next_scan(state.scan_input, state.scan_sel);
                  end
               end else begin
                  next_state.channel = state.channel + 2'd1;
               end
            end
         end
      endcase
      // Threshold reached: interrupt or DMA step, and buffer half swap.
      if (rate_hit) begin
         next_state.irq = !dma_on;
         next_state.dma_inc = dma_on;
         next_state.slot = 4'h0;
         if (state.ctl_two[adcsq_pkg::BIT_SPLIT]) begin
            next_state.half = !state.half;
            next_state.slot = state.half ? 4'h0 : 4'h8;
         end
      end
      if (!state.ctl_two[adcsq_pkg::BIT_SPLIT]) begin
         next_state.half = 1'b0;
      end
      next_state.dma_words = 8'h01 << state.dma_cfg[2:0];
      if (!conv_on) begin
         next_state.phase = adcsq_pkg::adcsq_idle;
         next_state.channel = 2'd0;
         next_state.conv_count = 5'h00;
         next_state.slot = 4'h0;
         next_state.half = 1'b0;
      end
      next_state.sampling = next_state.phase == adcsq_pkg::adcsq_sample;
   end

   // State register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops.
   // ---------------------------------------------------------------
   assign s_axi_awready = state.awready;
   assign s_axi_wready = state.wready;
   assign s_axi_bresp = state.bresp;
   assign s_axi_bvalid = state.bvalid;
   assign s_axi_arready = state.arready;
   assign s_axi_rdata = state.rdata;
   assign s_axi_rresp = state.rresp;
   assign s_axi_rvalid = state.rvalid;
   assign sample_active = state.sampling;
   assign conv_start = state.start;
   assign conv_done = state.done;
   assign conv_channel = state.channel;
   assign scan_input = state.scan_input;
   assign result_slot = state.slot;
   assign conv_irq = state.irq;
   assign dma_increment = state.dma_inc;
   assign dma_words = state.dma_words;

endmodule

// [test/adcsq_assertions.sv]
// Checker of the sequencing control ports.
`timescale 1ns/10ps
module adcsq_assertions (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Bus answers.
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Converter events.
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic conv_irq,
   input wire logic dma_increment,
   input wire logic [7:0] dma_words
);
   // ------------------------------------
   // Properties of the single clock domain.
   // ------------------------------------
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Routing picks either the interrupt or the DMA step, never both.
   property p_excl; !(conv_irq && dma_increment); endproperty
   a_excl: assert property (p_excl) else $error("irq and dma step together");
   // Threshold pulses only follow a finished conversion closely.
   property p_irq; conv_irq |-> conv_done || $past(conv_done) || $past(conv_done, 2); endproperty
   a_irq: assert property (p_irq) else $error("irq without conversion");
   property p_inc; dma_increment |-> conv_done || $past(conv_done) || $past(conv_done, 2); endproperty
   a_inc: assert property (p_inc) else $error("dma step without conversion");
   property p_words; $onehot0(dma_words); endproperty
   a_words: assert property (p_words) else $error("buffer words not a power of two");
   property p_pulse; conv_start |=> !conv_start; endproperty
   a_pulse: assert property (p_pulse) else $error("start longer than a cycle");
   // A conversion lasts many conversion clocks, so done cannot follow start at once.
   property p_span; conv_start |=> !conv_done [*8]; endproperty
   a_span: assert property (p_span) else $error("conversion too short");
   // Bus answers stand until taken.
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_rsrc; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready); endproperty
   a_rsrc: assert property (p_rsrc) else $error("read answer without request");
   property p_bresp; s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10}; endproperty
   a_bresp: assert property (p_bresp) else $error("bad write response code");
   property p_hi; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits not zero");
endmodule

// [test/adcsq_reader.sv]
// Model of the software and DMA reader that takes every conversion result.
`timescale 1ns/10ps
module adcsq_reader (
   // Clock and control.
   input wire logic aclk,
   input wire logic clear,
   // Converter events.
   input wire logic conv_start,
   input wire logic conv_done,
   input wire logic conv_irq,
   input wire logic dma_increment,
   input wire logic [1:0] conv_channel,
   input wire logic [3:0] result_slot,
   // Tallies.
   output int n_start,
   output int n_done,
   output int n_irq,
   output int n_inc,
   output int n_slot,
   output int span,
   output int max_ch
);
   int cyc;
   int t0;
   // The result is taken in the cycle it completes, so no later one can overwrite it.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (clear) begin
         n_start <= 0;
         n_done <= 0;
         n_irq <= 0;
         n_inc <= 0;
         n_slot <= 0;
         max_ch <= 0;
      end else begin
         if (conv_start) begin
            n_start <= n_start + 1;
            t0 <= cyc;
         end
         if (conv_done) begin
            n_done <= n_done + 1;
            span <= cyc - t0;
            n_slot <= n_slot + int'(result_slot != 4'h0);
            if (int'(conv_channel) > max_ch) max_ch <= int'(conv_channel);
         end
         n_irq <= n_irq + int'(conv_irq);
         n_inc <= n_inc + int'(dma_increment);
      end
   end
endmodule

// [test/tb_adc_sequencing_control.sv]
// Self-checking testbench of the converter sequencing control.
`timescale 1ns/10ps
module tb_adc_sequencing_control;
   localparam int CONV = 14;
   logic aclk = 1'b0, aresetn = 1'b0, clear = 1'b0, rc_tick = 1'b0, ext_trigger = 1'b0;
   logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, result_slot;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel;
   logic sample_active, conv_start, conv_done, conv_irq, dma_increment;
   logic [4:0] scan_input;
   logic [7:0] dma_words;
   logic [15:0] d;
   logic [33:0] exp_q[$], msk_q[$];
   int n_errors = 0, n_tests = 0, cyc = 0;
   int n_start, n_done, n_irq, n_inc, n_slot, span, max_ch;
   adcsq_top #(.CONV_CLOCKS(CONV)) i_dut (.*);
   adcsq_reader i_reader (.*);
   // Free clock; the slow tick stands in for the internal RC source.
   always #25 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      rc_tick <= (cyc % 4 == 3);
   end
   // -------------------------------
   // Compare, bus and closing tasks.
   // -------------------------------
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cnt(input int got, input int exp);
      chk({2'b00, got}, {2'b00, exp});
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] v, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({32'h0, s_axi_bresp}, {32'h0, r});
   endtask
   // Reads note the expected word; the watcher below compares when it arrives.
   task automatic rd(input logic [5:0] a, input logic [15:0] m, input logic [15:0] v, input logic [1:0] r);
      exp_q.push_back({r, 16'h0000, v & m});
      msk_q.push_back({2'b11, (m != 16'h0) ? 16'hFFFF : 16'h0, m});
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata} & msk_q[0], exp_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
   end
   task automatic clr();
      clear <= 1'b1;
      @(posedge aclk);
      clear <= 1'b0;
   endtask
   // A fresh run after a disable must count from zero, leftovers would shift the pulses.
   task automatic run(input logic [15:0] c2, input logic [15:0] c4, input int k, input int ei, input int ed,
                      input int mc);
      wr(adcsq_pkg::ADDR_CONTROL_TWO, c2, 2'b00);
      wr(adcsq_pkg::ADDR_DMA_CONFIG, c4, 2'b00);
      clr();
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h00E1, 2'b00);
      wait (n_done == k);
      repeat (4) @(posedge aclk);
      cnt(n_irq, ei);
      cnt(n_inc, ed);
      cnt(max_ch, mc);
      if (c4[8]) cnt(n_slot, 0);
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0000, 2'b00);
   endtask
   // Hang guard.
   initial begin
      #(40_000 * 50);
      n_errors++;
      final_report();
   end
   // ------------------------
   // Main sequence of tests.
   // ------------------------
   initial begin
      void'($urandom(32'h2f33));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(adcsq_pkg::ADDR_CONTROL_THREE, 16'hFFFF, 16'h0000, 2'b00);
      rd(adcsq_pkg::ADDR_DMA_CONFIG, 16'hFFFF, 16'h0000, 2'b00);
      rd(adcsq_pkg::ADDR_CH123_SELECT, 16'hFFFF, 16'h0000, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_THREE, 16'hFFFF, 2'b00);
      rd(adcsq_pkg::ADDR_CONTROL_THREE, 16'hFFFF, 16'h9FFF, 2'b00);
      for (int i = 0; i < 8; i++) begin
         d = (16'($urandom) & 16'hFEF8) | 16'(i);
         wr(adcsq_pkg::ADDR_DMA_CONFIG, d, 2'b00);
         rd(adcsq_pkg::ADDR_DMA_CONFIG, 16'hFFFF, d & 16'h0107, 2'b00);
         chk({26'h0, dma_words}, 34'(1 << i));
      end
      wr(adcsq_pkg::ADDR_CH123_SELECT, 16'hFFFF, 2'b00);
      rd(adcsq_pkg::ADDR_CH123_SELECT, 16'hFFFF, 16'h0707, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0400, 2'b00);
      rd(adcsq_pkg::ADDR_CH123_SELECT, 16'h0600, 16'h0000, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_TWO, 16'h0300, 2'b00);
      rd(adcsq_pkg::ADDR_CONTROL_TWO, 16'h0300, 16'h0000, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0000, 2'b00);
      wr(6'h1C, 16'h1234, 2'b10);
      rd(6'h1C, 16'h0000, 16'h0000, 2'b10);
      wr(adcsq_pkg::ADDR_CONTROL_THREE, 16'h0200, 2'b00);
      run(16'h000C, 16'h0000, 9, 2, 0, 0);
      run(16'h0244, 16'h0000, 7, 3, 0, 3);
      run(16'h0144, 16'h0100, 36, 0, 2, 1);
      run(16'h037C, 16'h0000, 16, 1, 0, 3);
      wr(adcsq_pkg::ADDR_CONTROL_THREE, 16'h0203, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_TWO, 16'h0406, 2'b00);
      wr(adcsq_pkg::ADDR_SCAN_SELECT, 16'h0024, 2'b00);
      clr();
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h00E1, 2'b00);
      wait (n_irq == 1);
      rd(adcsq_pkg::ADDR_CONTROL_TWO, 16'h0080, 16'h0080, 2'b00);
      wait (n_irq == 2);
      rd(adcsq_pkg::ADDR_CONTROL_TWO, 16'h0080, 16'h0000, 2'b00);
      cnt(int'(span >= CONV * 4 - 4 && span <= CONV * 4 + 8), 1);
      chk({29'h0, scan_input}, 34'h5);
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0000, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_THREE, 16'h82FF, 2'b00);
      clr();
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h00E1, 2'b00);
      wait (n_done == 2);
      cnt(int'(span >= CONV * 4 - 4 && span <= CONV * 4 + 8), 1);
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0000, 2'b00);
      wr(adcsq_pkg::ADDR_CONTROL_THREE, 16'h1F00, 2'b00);
      clr();
      wr(adcsq_pkg::ADDR_CONTROL_ONE, 16'h0021, 2'b00);
      repeat (200) @(posedge aclk);
      cnt(n_start, 0);
      chk({33'h0, sample_active}, 34'h1);
      ext_trigger <= 1'b1;
      wait (n_start == 1);
      @(posedge aclk);
      ext_trigger <= 1'b0;
      repeat (4) @(posedge aclk);
      final_report();
   end
endmodule
bind adcsq_top adcsq_assertions i_chk (.*);
